/* File: pwm_intensity_pkg.sv */
// Constants for the port PWM intensity block: register offsets,
// field positions, reset values and PWM timing counts.
// Assumes an 8-bit register port with byte-wide offsets.
package pwm_intensity_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_PHASE0_LO   = 8'h02;
   localparam logic [7:0] ADDR_PHASE0_HI   = 8'h03;
   localparam logic [7:0] ADDR_PHASE1_LO   = 8'h0A;
   localparam logic [7:0] ADDR_PHASE1_HI   = 8'h0B;
   localparam logic [7:0] ADDR_MASTER_GLB  = 8'h0E;
   localparam logic [7:0] ADDR_CONFIG      = 8'h0F;
   localparam logic [7:0] ADDR_INDIV_FIRST = 8'h10;
   localparam logic [7:0] ADDR_INDIV_LAST  = 8'h17;

   // ------------------------------------------------------------
   // Field positions in the configuration register
   // ------------------------------------------------------------
   localparam int CFG_PHASE_EN_BIT  = 0;
   localparam int CFG_PHASE_INV_BIT = 1;
   localparam int CFG_GLOBAL_BIT    = 2;
   localparam int CFG_X0_BIT        = 3;
   localparam int CFG_X1_BIT        = 4;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  RST_MASTER_GLB = 8'h00;
   localparam logic [7:0]  RST_CONFIG     = 8'h18;
   localparam logic [15:0] RST_PHASE      = 16'hFFFF;
   localparam logic [3:0]  RST_INDIV      = 4'hF;

   // ------------------------------------------------------------
   // PWM timing
   // ------------------------------------------------------------
   localparam int          NUM_OUT        = 17;
   localparam logic [3:0]  INTENS_FULL    = 4'hF;
   localparam logic [3:0]  SLOT_LAST      = 4'hE;
   localparam logic [3:0]  CYCLE_LAST     = 4'hF;
   // Oscillator tick: 32 kHz nominal
   localparam int          OSC_FREQ_HZ    = 32000;
   localparam int          CLK_FREQ_HZ    = 100000000;
   localparam int          TICK_CYCLES    = CLK_FREQ_HZ / OSC_FREQ_HZ;
   localparam logic [11:0] TICK_LAST      = 12'(TICK_CYCLES - 1);

endpackage

/* File: pwm_timebase.sv */
// PWM timebase: oscillator tick divider, 16 cycles per slot,
// 15 master slots per period.
// Assumes one 100 MHz clock and a synchronous low reset.
`timescale 1ns/1ps
module pwm_timebase
   import pwm_intensity_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // Run control
   input  wire logic       run_in,
   // Position in the period
   output logic [3:0]      slot_out,
   output logic [3:0]      cycle_out
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [11:0] div;    // Oscillator divider
      logic [3:0]  slot;   // Master timeslot 0..14
      logic [3:0]  cycle;  // PWM cycle within slot 0..15
   } tb_state_t;

   tb_state_t st_reg;
   tb_state_t st_next;

   // Advance counters; halt and clear while PWM is off to save power
   always_comb begin
      st_next = st_reg;
      if (!run_in) begin
         st_next = '0;
      end else if (st_reg.div == TICK_LAST) begin
         st_next.div = 12'h000;
         if (st_reg.cycle == CYCLE_LAST) begin
            st_next.cycle = 4'h0;
            st_next.slot  = (st_reg.slot == SLOT_LAST) ? 4'h0
                          : 4'(st_reg.slot + 4'h1);
         end else begin
            st_next.cycle = 4'(st_reg.cycle + 4'h1);
         end
      end else begin
         st_next.div = 12'(st_reg.div + 12'h001);
      end
   end

   // Register the state
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign slot_out  = st_reg.slot;
   assign cycle_out = st_reg.cycle;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_slot_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      st_reg.slot <= SLOT_LAST)
      else $error("slot counter beyond 15 slots");

endmodule

/* File: pwm_output_cell.sv */
// One output's PWM decision: level, intensity, master gate.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pwm_output_cell
   import pwm_intensity_pkg::*;
(
   // Settings
   input  wire logic       pwm_on_in,
   input  wire logic [3:0] intens_in,
   input  wire logic [3:0] master_in,
   input  wire logic       level_in,
   // Timebase
   input  wire logic [3:0] slot_in,
   input  wire logic [3:0] cycle_in,
   // Result: 1 means released (high impedance), 0 means driven low
   output logic            rel_out
);

   logic gate_open; // Slot is inside the master gate
   logic low_part;  // First (n+1)/16 of the slot

   // Select static or pulsed level
   always_comb begin
      gate_open = (slot_in < master_in);
      low_part  = (cycle_in <= intens_in);
      if (!pwm_on_in || intens_in == INTENS_FULL) begin
         rel_out = level_in;
      end else if (!gate_open) begin
         // Outside the gated slots the output rests at its off level
         rel_out = ~level_in;
      end else if (!level_in) begin
         rel_out = ~low_part;
      end else begin
         rel_out = low_part;
      end
   end

endmodule

/* File: port_pwm_intensity_control.sv */
// Top of the port PWM intensity block: register file, phase select,
// intensity selection and registered open-drain outputs.
// Assumes an 8-bit register port on the same clock and an external
// phase-select pin that is asynchronous to the clock.
//
// Operation
// - Phase selects phase-0 or phase-1 output level
// - Low nibble is extra output and global
// - Global flag replaces all 16 port settings
// - Master and global combine into 240 steps
// - Global mode applies to every output
// - Master 0x00-0x0F makes all outputs static
// - Master 0x10-0xFF enables PWM
// - Individual 0xF gives static output
// - Individual 0x0-0xE gives PWM output
// - Global mode ignores individual registers
// - Bit 0: low for (n+1)/16
// - Bit 1: released for (n+1)/16
// - Setting 0xF: static level, no PWM
// - Period is 15 slots of 16 cycles
// - Master gates 1 to 15 slots
// - Full scale ignores master gate
// - Phase-1 when enable and invert XOR pin
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module port_pwm_intensity_control
   import pwm_intensity_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   // Phase-select pin
   input  wire logic        phase_pin_in,
   // Port pins and extra output, open drain
   output logic      [15:0] port_pins_o_out,
   output logic      [15:0] port_pins_oe_out,
   output logic             extra_output_o_out,
   output logic             extra_output_oe_out,
   // Status
   output logic             pwm_active_out
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] phase0;      // Phase-0 output levels
      logic [15:0] phase1;      // Phase-1 output levels
      logic [7:0]  master_glb;  // Master (high) and global (low)
      logic [7:0]  config_r;    // Phase, invert, global, extra out
      logic [63:0] indiv;       // 16 nibbles of port intensity
      logic [7:0]  rdata;       // Read data, one cycle later
      logic [1:0]  pin_sync;    // Phase pin synchroniser
      logic [16:0] release_o;   // Registered output release
      logic        pwm_active;  // PWM enabled flag
   } top_state_t;

   top_state_t st_reg;
   top_state_t st_next;

   // Per-output signals into the cells
   logic [3:0]  intens_sel [NUM_OUT];
   logic [16:0] level_sel;
   logic [16:0] rel_comb;
   logic [3:0]  slot_w;
   logic [3:0]  cycle_w;
   logic        pwm_on;
   logic        use_phase1;
   logic        global_mode;

   // Decodes whether an address is one of the individual registers
   function automatic logic is_indiv(input logic [7:0] a);
      return (a >= ADDR_INDIV_FIRST) && (a <= ADDR_INDIV_LAST);
   endfunction

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   // PWM runs only with a nonzero master nibble
   assign pwm_on = (st_reg.master_glb[7:4] != 4'h0);
   assign global_mode = st_reg.config_r[CFG_GLOBAL_BIT];

   // Phase choice; the pin is read only after two flops
   assign use_phase1 = st_reg.config_r[CFG_PHASE_EN_BIT] &
                       (st_reg.config_r[CFG_PHASE_INV_BIT] ^
                        st_reg.pin_sync[1]);

   // ------------------------------------------------------------
   // Intensity and level selection per output
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_port
         // Global nibble overrides the port nibble in global mode
         assign intens_sel[g] = global_mode
                              ? st_reg.master_glb[3:0]
                              : st_reg.indiv[g*4 +: 4];
         assign level_sel[g] = use_phase1 ? st_reg.phase1[g]
                                          : st_reg.phase0[g];
      end
   endgenerate

   // Extra output always uses the low nibble, global or not
   assign intens_sel[16] = st_reg.master_glb[3:0];
   assign level_sel[16]  = use_phase1
                         ? st_reg.config_r[CFG_X1_BIT]
                         : st_reg.config_r[CFG_X0_BIT];

   // ------------------------------------------------------------
   // Timebase and output cells
   // ------------------------------------------------------------
   pwm_timebase u_timebase (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .run_in    (pwm_on),
      .slot_out  (slot_w),
      .cycle_out (cycle_w)
   );

   // Same master and timebase for all: global mode has no exclusion
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_cell
         pwm_output_cell u_cell (
            .pwm_on_in (pwm_on),
            .intens_in (intens_sel[g]),
            .master_in (st_reg.master_glb[7:4]),
            .level_in  (level_sel[g]),
            .slot_in   (slot_w),
            .cycle_in  (cycle_w),
            .rel_out   (rel_comb[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.pin_sync   = {st_reg.pin_sync[0], phase_pin_in};
      st_next.release_o  = rel_comb;
      st_next.pwm_active = pwm_on;
      st_next.rdata      = 8'h00;
      // Register writes
      if (wr_in) begin
         case (addr_in)
            ADDR_PHASE0_LO:  st_next.phase0[7:0]  = wdata_in;
            ADDR_PHASE0_HI:  st_next.phase0[15:8] = wdata_in;
            ADDR_PHASE1_LO:  st_next.phase1[7:0]  = wdata_in;
            ADDR_PHASE1_HI:  st_next.phase1[15:8] = wdata_in;
            ADDR_MASTER_GLB: st_next.master_glb   = wdata_in;
            ADDR_CONFIG:     st_next.config_r     = {3'h0, wdata_in[4:0]};
            default: begin
               // Each individual register holds two port nibbles
               if (is_indiv(addr_in)) begin
                  st_next.indiv[addr_in[2:0]*8 +: 8] = wdata_in;
               end
            end
         endcase
      end
      // Register reads; unmapped addresses read zero
      if (rd_in) begin
         case (addr_in)
            ADDR_PHASE0_LO:  st_next.rdata = st_reg.phase0[7:0];
            ADDR_PHASE0_HI:  st_next.rdata = st_reg.phase0[15:8];
            ADDR_PHASE1_LO:  st_next.rdata = st_reg.phase1[7:0];
            ADDR_PHASE1_HI:  st_next.rdata = st_reg.phase1[15:8];
            ADDR_MASTER_GLB: st_next.rdata = st_reg.master_glb;
            ADDR_CONFIG:     st_next.rdata = st_reg.config_r;
            default: begin
               if (is_indiv(addr_in)) begin
                  st_next.rdata = st_reg.indiv[addr_in[2:0]*8 +: 8];
               end
            end
         endcase
      end
   end

   // Register the state
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg            <= '0;
         st_reg.phase0     <= RST_PHASE;
         st_reg.phase1     <= RST_PHASE;
         st_reg.master_glb <= RST_MASTER_GLB;
         st_reg.config_r   <= RST_CONFIG;
         st_reg.indiv      <= {16{RST_INDIV}};
         st_reg.release_o  <= 17'h1FFFF;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs, from flops or tied low
   // ------------------------------------------------------------
   // Open drain: data is always low, enable drives the pin low
   assign port_pins_o_out     = 16'h0000;
   assign extra_output_o_out  = 1'b0;
   assign port_pins_oe_out    = ~st_reg.release_o[15:0];
   assign extra_output_oe_out = ~st_reg.release_o[16];
   assign rdata_out           = st_reg.rdata;
   assign pwm_active_out      = st_reg.pwm_active;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_static_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!pwm_on && !use_phase1) |=> (port_pins_oe_out == ~$past(st_reg.phase0)))
      else $error("static output not following phase-0 level");
   a_pwm_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (st_reg.master_glb >= 8'h10) |=> pwm_active_out)
      else $error("PWM not active for master above 0x0F");
   a_full_static: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!global_mode && st_reg.indiv[3:0] == INTENS_FULL)
      |=> (port_pins_oe_out[0] == ~$past(level_sel[0])))
      else $error("full-scale output not static");
   a_global_over: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      global_mode |-> (intens_sel[5] == st_reg.master_glb[3:0]))
      else $error("global setting not applied");
   a_extra_intens: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      intens_sel[16] == st_reg.master_glb[3:0])
      else $error("extra output not using low nibble");
   a_phase_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !st_reg.config_r[CFG_PHASE_EN_BIT] |-> (level_sel[15:0] == st_reg.phase0))
      else $error("phase-1 used while phase disabled");
   a_low_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (pwm_on && cycle_w == 4'h0 && slot_w == 4'h0 && !level_sel[1]
       && intens_sel[1] != INTENS_FULL) |=> port_pins_oe_out[1])
      else $error("output not low in first cycle");
   a_high_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (pwm_on && cycle_w == 4'h0 && slot_w == 4'h0 && level_sel[1]
       && intens_sel[1] != INTENS_FULL) |=> !port_pins_oe_out[1])
      else $error("inverted output low in first cycle");
   a_read_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (rd_in && addr_in == ADDR_MASTER_GLB && !wr_in)
      |=> (rdata_out == $past(st_reg.master_glb)))
      else $error("intensity register read back wrong");

   c_global: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      global_mode && pwm_on);
   c_phase1: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      use_phase1 && pwm_on);
   c_period: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      slot_w == SLOT_LAST && cycle_w == CYCLE_LAST);

endmodule

/* File: load_bank.sv */
// Load bank on the open-drain outputs: pull-ups and low-time counters.
// Assumes one enable bit per line, high while the device pulls it low.
`timescale 1ns/1ps
module load_bank (
   // Clock
   input  wire logic        clk_in,
   // Open-drain enables, extra output in the top bit
   input  wire logic [16:0] oe_in,
   // Counter control
   input  wire logic        clr_in,
   input  wire logic        count_in,
   // Line levels and low-time counts
   output logic      [16:0] level_out,
   output logic      [31:0] low_cnt_out [17]
);
   // ------------------------------------------------------------
   // Wire level
   // ------------------------------------------------------------
   // A pull-up lifts any released line; no other party drives it
   assign level_out = ~oe_in;

   // ------------------------------------------------------------
   // Low-time counters
   // ------------------------------------------------------------
   // Counting the wire level, not the enable, judges what a load sees
   always_ff @(posedge clk_in) begin
      for (int k = 0; k < 17; k++) begin
         if (clr_in) begin
            low_cnt_out[k] <= '0;
         end else if (count_in && !level_out[k]) begin
            low_cnt_out[k] <= low_cnt_out[k] + 32'd1;
         end
      end
   end
endmodule

/* File: testbench.sv */
// Self-checking bench for the port PWM intensity block.
// Assumes the load bank on the far side; one 100 MHz clock.
`timescale 1ns/1ps
module testbench
   import pwm_intensity_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk_in = 1'b0;     // Bench clock
   logic        rst_n_in;          // Synchronous reset
   logic [7:0]  addr_in;           // Register address
   logic [7:0]  wdata_in;          // Write data
   logic        wr_in;             // Write strobe
   logic        rd_in;             // Read strobe
   logic [7:0]  rdata_out;         // Read data
   logic        phase_pin_in;      // Phase-select pin
   logic [15:0] port_pins_o_out;   // Open-drain data
   logic [15:0] port_pins_oe_out;  // Port pull-down enables
   logic        extra_output_o_out;
   logic        extra_output_oe_out;
   logic        pwm_active_out;    // PWM running flag
   logic [16:0] oe_all;            // Extra output over port pins
   logic [16:0] level;             // Wire levels
   logic [31:0] low_cnt [17];      // Low clocks per line
   logic        clr;               // Counter clear
   logic        count;             // Counter enable
   int          errors = 0;
   int          n_compared = 0;
   // Intensity bytes, repeated over the eight paired registers
   logic [7:0]  iset [4] = '{8'h10, 8'h32, 8'h54, 8'hF6};

   assign oe_all = {extra_output_oe_out, port_pins_oe_out};
   always #5 clk_in = ~clk_in;

   // ------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------
   port_pwm_intensity_control i_port_pwm_intensity_control (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .phase_pin_in(phase_pin_in),
      .port_pins_o_out(port_pins_o_out),
      .port_pins_oe_out(port_pins_oe_out),
      .extra_output_o_out(extra_output_o_out),
      .extra_output_oe_out(extra_output_oe_out),
      .pwm_active_out(pwm_active_out));
   load_bank i_load_bank (
      .clk_in(clk_in), .oe_in(oe_all), .clr_in(clr),
      .count_in(count), .level_out(level), .low_cnt_out(low_cnt));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // One-cycle write strobe beside address and data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 check("rdata", {24'h0, rdata_out}, {24'h0, exp});
   endtask
   // Low clocks expected over one slot for setting n and level bit b
   function automatic logic [31:0] low_exp(input logic [3:0] n,
                                           input logic b);
      if (n == 4'hF) return b ? 32'd0 : 32'd16 * TICK_CYCLES;
      return (b ? 32'd15 - n : n + 32'd1) * TICK_CYCLES;
   endfunction
   task automatic complete_run;
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rchk(ADDR_MASTER_GLB, 8'h00);
      rchk(ADDR_CONFIG, 8'h18);
      rchk(ADDR_PHASE1_HI, 8'hFF);
      rchk(ADDR_INDIV_LAST, 8'hFF);
      rchk(8'h20, 8'h00);
      check("oe", {15'h0, oe_all}, 32'h0);
      check("o", {15'h0, extra_output_o_out, port_pins_o_out}, 32'h0);
      check("active", {31'h0, pwm_active_out}, 32'h0);
   endtask
   // Static mode, every combination of enable, invert and pin
   task automatic t_phase;
      logic [7:0] cfg;
      logic       p1;
      wr(ADDR_MASTER_GLB, 8'h0F);
      wr(ADDR_INDIV_FIRST, 8'h00);
      wr(ADDR_PHASE0_LO, 8'h00);
      wr(ADDR_PHASE1_LO, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         cfg = 8'hF0 | {6'h0, i[1], i[2]};
         p1 = i[2] & (i[1] ^ i[0]);
         wr(ADDR_CONFIG, cfg);
         phase_pin_in <= i[0];
         repeat (6) @(posedge clk_in);
         check("phase oe", {15'h0, oe_all}, {15'h0, ~p1, 8'h00,
               p1 ? 8'h00 : 8'hFF});
         check("active", {31'h0, pwm_active_out}, 32'h0);
         rchk(ADDR_CONFIG, cfg & 8'h1F);
      end
   endtask
   // Individual settings over one gated slot, then an ungated slot
   task automatic t_indiv;
      logic [3:0] n;
      logic [31:0] e;
      wr(ADDR_CONFIG, 8'h18);
      wr(ADDR_MASTER_GLB, 8'h00);
      wr(ADDR_PHASE0_HI, 8'hFF);
      // Shared PWM values go into each register, not global mode
      for (int j = 0; j < 8; j++) wr(ADDR_INDIV_FIRST + 8'(j), iset[j % 4]);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      wr(ADDR_MASTER_GLB, 8'h17);
      count <= 1'b1;
      repeat (16 * TICK_CYCLES) @(posedge clk_in);
      count <= 1'b0;
      check("active", {31'h0, pwm_active_out}, 32'h1);
      for (int k = 0; k < 17; k++) begin
         n = (k == 16) ? 4'h7 : iset[(k / 2) % 4][4 * (k % 2) +: 4];
         e = low_exp(n, k >= 8);
         check($sformatf("low time %0d", k),
               {31'h0, (low_cnt[k] + 8 >= e) && (low_cnt[k] <= e + 8)},
               32'h1);
      end
      repeat (1500) @(posedge clk_in);
      check("ungated", {15'h0, oe_all}, 32'h17F80);
   endtask
   // Global setting overrides every individual one, 0xF included
   task automatic t_global;
      wr(ADDR_MASTER_GLB, 8'h00);
      wr(ADDR_CONFIG, 8'h1C);
      wr(ADDR_MASTER_GLB, 8'h13);
      rchk(ADDR_MASTER_GLB, 8'h13);
      repeat (2 * TICK_CYCLES + 1000) @(posedge clk_in);
      check("global on", {15'h0, oe_all}, 32'h000FF);
      repeat (3 * TICK_CYCLES) @(posedge clk_in);
      check("global off", {15'h0, oe_all}, 32'h1FF00);
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      rst_n_in = 1'b0;
      addr_in = 8'h00;
      wdata_in = 8'h00;
      wr_in = 1'b0;
      rd_in = 1'b0;
      phase_pin_in = 1'b0;
      clr = 1'b1;
      count = 1'b0;
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      clr <= 1'b0;
      t_reset();
      t_phase();
      t_indiv();
      t_global();
      complete_run();
   end
   // Tests take about 68000 cycles; 90000 means a hang
   initial begin
      #900000;
      errors++;
      complete_run();
   end
endmodule
